// ===== bench/riocfg_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module riocfg_far_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [3:0] delay,
  input  wire logic       flash_write_req,
  output var  logic       flash_done
);
  // ---------------------------------------------------------------
  // flash store: one done pulse per write, after a set delay
  // ---------------------------------------------------------------
  logic [4:0] count;

  // delay counter, done pulse the cycle after it reaches one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count      <= 5'h00;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (count == 5'h01);
      if (flash_write_req) begin
        count <= {1'b0, delay} + 5'h01;
      end else if (count != 5'h00) begin
        count <= count - 5'h01;
      end
    end
  end
endmodule // riocfg_far_model
`default_nettype wire

// ===== bench/test_riocfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_riocfg_top;
  // ---------------------------------------------------------------
  // stimulus, expectations and verdict
  // ---------------------------------------------------------------
  localparam int SL = 8;
  localparam int DW = 16;
  logic                     clock, rst_n, remote_io_capable;
  logic                     unit_setup_command_bit;
  riocfg_pkg::riocfg_area_t out_area_sel, in_area_sel, stat_area_sel;
  logic [15:0]              out_first_word, in_first_word, stat_first_word;
  logic [15:0]              f;
  logic                     out_first_valid, in_first_valid, stat_first_valid;
  logic [15:0]              out_words_used, in_words_used;
  logic                     auto_save_setting, in_clear_setting;
  logic                     abs_encoder, offset_update;
  logic [1:0]               feed_mode;
  logic                     flash_done, save_data_cmd;
  logic [SL-1:0]            slave_is_remote_io, slave_is_sync_link;
  logic [SL-1:0]            slave_comm_error, slave_in_valid;
  logic [SL*DW-1:0]         slave_in_data, slave_in_image;
  logic [2:0]               out_area_type, in_area_type, stat_area_type;
  logic [15:0]              out_base, out_last, in_base, in_last;
  logic [15:0]              stat_base, stat_last;
  logic                     out_access_en, in_access_en, stat_access_en;
  logic                     range_error;
  logic                     auto_save_active, flash_write_req;
  logic                     data_transfer_flag;
  logic                     save_warning, save_accept;
  logic [3:0]               fl_delay;
  logic [DW-1:0]            exp_img [SL];
  int                       seed, fails, n_checks, cycles;

  riocfg_top riocfg_top_i (.clock, .rst_n, .remote_io_capable,
    .unit_setup_command_bit, .out_area_sel, .out_first_word,
    .out_first_valid, .in_area_sel, .in_first_word, .in_first_valid,
    .stat_area_sel, .stat_first_word, .stat_first_valid, .out_words_used,
    .in_words_used, .auto_save_setting, .in_clear_setting, .feed_mode,
    .abs_encoder, .offset_update, .flash_done, .save_data_cmd,
    .slave_is_remote_io, .slave_is_sync_link, .slave_comm_error,
    .slave_in_valid, .slave_in_data, .out_area_type, .out_base, .out_last,
    .out_access_en, .in_area_type, .in_base, .in_last, .in_access_en,
    .stat_area_type, .stat_base, .stat_last, .stat_access_en, .range_error,
    .auto_save_active, .flash_write_req, .data_transfer_flag, .save_warning,
    .save_accept, .slave_in_image);

  riocfg_far_model riocfg_far_model_i (.clock, .rst_n, .delay(fl_delay),
    .flash_write_req, .flash_done);

  // clock and hang guard
  always #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // highest legal word of each area type
  function automatic logic [15:0] lim(input int t);
    case (t)
      1: lim = 16'h17FF;
      2, 3: lim = 16'h01FF;
      4, 5: lim = 16'h7FFF;
      default: lim = 16'h0100;
    endcase
  endfunction

  // expected image lane: new data, zeroed, or held
  function automatic logic [DW-1:0] lane(input logic [DW-1:0] prev, dat,
    input logic err, vld, clr, rio, syn);
    if (err) lane = (clr && rio && !syn) ? '0 : prev;
    else lane = vld ? dat : prev;
  endfunction

  task automatic do_save(input logic exp);
    logic req, warn, acc;
    int k;
    req = 0;
    warn = 0;
    acc = 0;
    k = 0;
    offset_update = 1;
    @(negedge clock);
    offset_update = 0;
    repeat (3) begin
      req |= flash_write_req;
      @(negedge clock);
    end
    chk("flash_write_req", exp, req);
    chk("transfer_flag", exp, data_transfer_flag);
    chk("save_active", exp, auto_save_active);
    save_data_cmd = 1;
    @(negedge clock);
    save_data_cmd = 0;
    repeat (2) begin
      warn |= save_warning;
      acc |= save_accept;
      @(negedge clock);
    end
    chk("save_warning", exp, warn);
    chk("save_accept", !exp, acc);
    while (data_transfer_flag === 1'b1 && k < 40) begin
      @(negedge clock);
      k++;
    end
    chk("transfer_end", 0, data_transfer_flag);
  endtask

  task automatic img_step(input logic [SL-1:0] err, vld);
    slave_in_data = {$random(seed), $random(seed), $random(seed),
                     $random(seed)};
    slave_comm_error = err;
    slave_in_valid = vld;
    repeat (3) @(negedge clock);
    for (int g = 0; g < SL; g++) begin
      exp_img[g] = lane(exp_img[g], slave_in_data[g*DW+:DW], err[g], vld[g],
        in_clear_setting, slave_is_remote_io[g], slave_is_sync_link[g]);
      chk("in_image", exp_img[g], slave_in_image[g*DW+:DW]);
    end
  endtask

  // main sequence
  initial begin
    seed = 32'hCDEF;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    clock = 0;
    rst_n = 0;
    remote_io_capable = 1;
    unit_setup_command_bit = 0;
    out_area_sel = riocfg_pkg::RIOCFG_AREA_NONE;
    in_area_sel = riocfg_pkg::RIOCFG_AREA_NONE;
    stat_area_sel = riocfg_pkg::RIOCFG_AREA_NONE;
    out_first_word = 0;
    in_first_word = 0;
    stat_first_word = 0;
    f = 0;
    out_first_valid = 0;
    in_first_valid = 0;
    stat_first_valid = 0;
    out_words_used = 16'h0010;
    in_words_used = 16'h0008;
    auto_save_setting = 0; // reset default must win until setup
    in_clear_setting = 0;
    feed_mode = 2'h1;
    abs_encoder = 1;
    offset_update = 0;
    save_data_cmd = 0;
    fl_delay = 4'hA;
    slave_is_remote_io = 0;
    slave_is_sync_link = 0;
    slave_comm_error = 0;
    slave_in_valid = 0;
    slave_in_data = 0;
    repeat (4) @(negedge clock);
    rst_n = 1;
    repeat (2) @(negedge clock);
    chk("out_base", 16'h0ED8, out_base);
    chk("in_base", 16'h0F3C, in_base);
    chk("stat_base", 16'h0F8C, stat_base);
    chk("stat_last", 16'h0F9F, stat_last);
    chk("out_last", 16'h0EE7, out_last);
    chk("out_type", 16'h0001, out_area_type);
    // every area type, first word kept inside the area
    for (int t = 0; t < 6; t++) begin
      f = 16'(($random(seed) & 32'h7FFF) % (lim(t) - 16'h0020));
      in_words_used = 16'(t * 3);
      out_area_sel = riocfg_pkg::riocfg_area_t'(t);
      in_area_sel = riocfg_pkg::riocfg_area_t'(t);
      stat_area_sel = riocfg_pkg::riocfg_area_t'(t);
      out_first_word = f;
      in_first_word = f;
      stat_first_word = f;
      out_first_valid = 1;
      in_first_valid = 1;
      stat_first_valid = 1;
      @(negedge clock);
      out_first_valid = 0;
      in_first_valid = 0;
      stat_first_valid = 0;
      repeat (3) @(negedge clock);
      chk("out_type", 16'(t), out_area_type);
      chk("in_type", 16'(t), in_area_type);
      chk("stat_type", 16'(t), stat_area_type);
      chk("out_access", t != 0, out_access_en);
      chk("in_access", t != 0, in_access_en);
      chk("stat_access", t != 0, stat_access_en);
      chk("range_error", 0, range_error);
      if (t != 0) begin
        chk("out_last", f + out_words_used - 16'h0001, out_last);
        chk("in_last", f + 16'(t * 3) - 16'h0001, in_last);
        chk("stat_last", f + 16'h0013, stat_last);
      end
    end
    // corner: status block runs past the end of the work area
    stat_area_sel = riocfg_pkg::RIOCFG_AREA_WORK;
    stat_first_word = 16'h01F0;
    stat_first_valid = 1;
    @(negedge clock);
    stat_first_valid = 0;
    repeat (3) @(negedge clock);
    chk("range_error", 1, range_error);
    chk("stat_access", 1, stat_access_en);
    chk("stat_last", 16'h0203, stat_last);
    remote_io_capable = 0;
    repeat (3) @(negedge clock);
    chk("incap_type", 0, out_area_type);
    chk("incap_acc", 0, {in_access_en, out_access_en, stat_access_en});
    chk("incap_range", 0, range_error);
    remote_io_capable = 1;
    do_save(1);
    auto_save_setting = 0;
    do_save(1);
    unit_setup_command_bit = 1;
    @(negedge clock);
    unit_setup_command_bit = 0;
    do_save(0);
    auto_save_setting = 1;
    unit_setup_command_bit = 1;
    @(negedge clock);
    unit_setup_command_bit = 0;
    feed_mode = 2'h2;
    do_save(0);
    feed_mode = 2'h1;
    do_save(1);
    slave_is_remote_io = 8'($random(seed));
    slave_is_sync_link = 8'($random(seed));
    for (int g = 0; g < SL; g++) exp_img[g] = '0;
    img_step('0, '1);
    for (int i = 0; i < 8; i++) begin
      in_clear_setting = 1'($random(seed));
      @(negedge clock); // clear mode is taken one edge later
      img_step(8'($random(seed)), 8'($random(seed)));
    end
    complete_run();
  end
endmodule // test_riocfg_top
`default_nettype wire

// ===== hdl/riocfg_pkg.sv
package riocfg_pkg;

  // ---------------------------------------------------------------
  // area types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RIOCFG_AREA_NONE = 3'h0,
    RIOCFG_AREA_CORE = 3'h1,
    RIOCFG_AREA_WORK = 3'h2,
    RIOCFG_AREA_HOLD = 3'h3,
    RIOCFG_AREA_DATA = 3'h4,
    RIOCFG_AREA_EXT  = 3'h5
  } riocfg_area_t;

  // ---------------------------------------------------------------
  // word ranges and defaults
  // ---------------------------------------------------------------
  localparam logic [15:0] CORE_MAX_WORD    = 16'h17FF; // 6143
  localparam logic [15:0] WORK_MAX_WORD    = 16'h01FF; // 511
  localparam logic [15:0] HOLD_MAX_WORD    = 16'h01FF; // 511
  localparam logic [15:0] DATA_MAX_WORD    = 16'h7FFF; // 32767
  localparam logic [15:0] EXT_MAX_WORD     = 16'h7FFF; // per bank
  localparam logic [15:0] OUT_FIRST_RESET  = 16'h0ED8; // 3800
  localparam logic [15:0] IN_FIRST_RESET   = 16'h0F3C; // 3900
  localparam logic [15:0] STAT_FIRST_RESET = 16'h0F8C; // 3980
  localparam logic [15:0] STAT_WORDS       = 16'h0014; // 20
  localparam logic        AUTO_SAVE_RESET  = 1'b1;
  localparam logic        IN_CLEAR_RESET   = 1'b0;
  localparam logic [1:0]  FEED_ROTARY_INF  = 2'h1;

  // ---------------------------------------------------------------
  // save sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RIOCFG_IDLE  = 2'b00,
    RIOCFG_SAVE  = 2'b01,
    RIOCFG_DONE  = 2'b11
  } riocfg_state_t;

endpackage

// ===== hdl/riocfg_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - area select is none or five types
// - output area defaults to core word 3800
// - input area defaults to core word 3900
// - status area defaults to core word 3980
// - status area spans twenty words
// - in/out size follows connected slaves
// - no areas on variants lacking remote I/O
// - rotary mode 1 with enable saves offset
// - auto save bit defaults to one
// - auto save bit latched at setup only
// - saving holds transfer flag, warns save
// - clear mode zeros inputs on error
// - clear mode bit defaults to zero
// - clear affects remote I/O slaves only
// - synchronous link data always retained
module riocfg_top #(
  parameter int SLAVES = 8,
  parameter int DATA_W = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     remote_io_capable,
  input  wire logic                     unit_setup_command_bit,
  input  wire riocfg_pkg::riocfg_area_t out_area_sel,
  input  wire logic [15:0]              out_first_word,
  input  wire logic                     out_first_valid,
  input  wire riocfg_pkg::riocfg_area_t in_area_sel,
  input  wire logic [15:0]              in_first_word,
  input  wire logic                     in_first_valid,
  input  wire riocfg_pkg::riocfg_area_t stat_area_sel,
  input  wire logic [15:0]              stat_first_word,
  input  wire logic                     stat_first_valid,
  input  wire logic [15:0]              out_words_used,
  input  wire logic [15:0]              in_words_used,
  input  wire logic                     auto_save_setting,
  input  wire logic                     in_clear_setting,
  input  wire logic [1:0]               feed_mode,
  input  wire logic                     abs_encoder,
  input  wire logic                     offset_update,
  input  wire logic                     flash_done,
  input  wire logic                     save_data_cmd,
  input  wire logic [SLAVES-1:0]        slave_is_remote_io,
  input  wire logic [SLAVES-1:0]        slave_is_sync_link,
  input  wire logic [SLAVES-1:0]        slave_comm_error,
  input  wire logic [SLAVES-1:0]        slave_in_valid,
  input  wire logic [SLAVES*DATA_W-1:0] slave_in_data,
  output var  logic [2:0]               out_area_type,
  output var  logic [15:0]              out_base,
  output var  logic [15:0]              out_last,
  output var  logic                     out_access_en,
  output var  logic [2:0]               in_area_type,
  output var  logic [15:0]              in_base,
  output var  logic [15:0]              in_last,
  output var  logic                     in_access_en,
  output var  logic [2:0]               stat_area_type,
  output var  logic [15:0]              stat_base,
  output var  logic [15:0]              stat_last,
  output var  logic                     stat_access_en,
  output var  logic                     range_error,
  output var  logic                     auto_save_active,
  output var  logic                     flash_write_req,
  output var  logic                     data_transfer_flag,
  output var  logic                     save_warning,
  output var  logic                     save_accept,
  output var  logic [SLAVES*DATA_W-1:0] slave_in_image
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // highest legal word for an area type
  function automatic logic [15:0] area_max(riocfg_pkg::riocfg_area_t a);
    unique case (a)
      riocfg_pkg::RIOCFG_AREA_CORE: area_max = riocfg_pkg::CORE_MAX_WORD;
      riocfg_pkg::RIOCFG_AREA_WORK: area_max = riocfg_pkg::WORK_MAX_WORD;
      riocfg_pkg::RIOCFG_AREA_HOLD: area_max = riocfg_pkg::HOLD_MAX_WORD;
      riocfg_pkg::RIOCFG_AREA_DATA: area_max = riocfg_pkg::DATA_MAX_WORD;
      riocfg_pkg::RIOCFG_AREA_EXT:  area_max = riocfg_pkg::EXT_MAX_WORD;
      default:                      area_max = 16'h0000;
    endcase
  endfunction
  // legal type that is not "no setting"
  function automatic logic area_used(riocfg_pkg::riocfg_area_t a);
    area_used = (a != riocfg_pkg::RIOCFG_AREA_NONE) &&
                (a <= riocfg_pkg::RIOCFG_AREA_EXT);
  endfunction
  // last word of span, 17 bits to catch wrap
  function automatic logic [16:0] span_last(logic [15:0] b,
                                            logic [15:0] n);
    span_last = {1'b0, b} + {1'b0, n} - 17'h00001;
  endfunction
  // span exceeds area range
  function automatic logic span_bad(riocfg_pkg::riocfg_area_t a,
                                    logic [15:0] b, logic [15:0] n);
    span_bad = area_used(a) && (n != 16'h0000) &&
               (span_last(b, n) > {1'b0, area_max(a)});
  endfunction

  // ---------------------------------------------------------------
  // area placement
  // ---------------------------------------------------------------
  riocfg_pkg::riocfg_area_t out_sel_q;
  riocfg_pkg::riocfg_area_t in_sel_q;
  riocfg_pkg::riocfg_area_t stat_sel_q;
  logic [15:0]              out_base_q;
  logic [15:0]              in_base_q;
  logic [15:0]              stat_base_q;

  // first words, reset to core area defaults
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_sel_q   <= riocfg_pkg::RIOCFG_AREA_CORE;
      out_base_q  <= riocfg_pkg::OUT_FIRST_RESET;
      in_sel_q    <= riocfg_pkg::RIOCFG_AREA_CORE;
      in_base_q   <= riocfg_pkg::IN_FIRST_RESET;
      stat_sel_q  <= riocfg_pkg::RIOCFG_AREA_CORE;
      stat_base_q <= riocfg_pkg::STAT_FIRST_RESET;
    end else begin
      if (out_first_valid) begin
        out_sel_q  <= out_area_sel;
        out_base_q <= out_first_word;
      end
      if (in_first_valid) begin
        in_sel_q  <= in_area_sel;
        in_base_q <= in_first_word;
      end
      if (stat_first_valid) begin
        stat_sel_q  <= stat_area_sel;
        stat_base_q <= stat_first_word;
      end
    end
  end

  // published placement and access enables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_area_type  <= 3'h0;
      out_base       <= 16'h0000;
      out_last       <= 16'h0000;
      out_access_en  <= 1'b0;
      in_area_type   <= 3'h0;
      in_base        <= 16'h0000;
      in_last        <= 16'h0000;
      in_access_en   <= 1'b0;
      stat_area_type <= 3'h0;
      stat_base      <= 16'h0000;
      stat_last      <= 16'h0000;
      stat_access_en <= 1'b0;
      range_error    <= 1'b0;
    end else begin
      out_area_type  <= remote_io_capable ? out_sel_q : 3'h0;
      in_area_type   <= remote_io_capable ? in_sel_q : 3'h0;
      stat_area_type <= remote_io_capable ? stat_sel_q : 3'h0;
      out_base       <= out_base_q;
      in_base        <= in_base_q;
      stat_base      <= stat_base_q;
      out_last  <= 16'(span_last(out_base_q, out_words_used));
      in_last   <= 16'(span_last(in_base_q, in_words_used));
      stat_last <= 16'(span_last(stat_base_q,
                                 riocfg_pkg::STAT_WORDS));
      out_access_en  <= remote_io_capable && area_used(out_sel_q)
                        && (out_words_used != 16'h0000);
      in_access_en   <= remote_io_capable && area_used(in_sel_q)
                        && (in_words_used != 16'h0000);
      stat_access_en <= remote_io_capable && area_used(stat_sel_q);
      // host misplacement flagged, area still served
      range_error <= remote_io_capable &&
        (span_bad(out_sel_q, out_base_q, out_words_used) ||
         span_bad(in_sel_q, in_base_q, in_words_used) ||
         span_bad(stat_sel_q, stat_base_q,
                  riocfg_pkg::STAT_WORDS));
    end
  end

  // ---------------------------------------------------------------
  // behaviour settings
  // ---------------------------------------------------------------
  logic auto_save_q;
  logic in_clear_q;
  // auto save loads its default at reset, setting taken at setup command only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      auto_save_q <= riocfg_pkg::AUTO_SAVE_RESET;
    end else if (unit_setup_command_bit) begin
      auto_save_q <= auto_save_setting;
    end
  end

  // clear mode follows its input
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      in_clear_q <= riocfg_pkg::IN_CLEAR_RESET;
    end else begin
      in_clear_q <= in_clear_setting;
    end
  end

  // ---------------------------------------------------------------
  // automatic offset save
  // ---------------------------------------------------------------
  riocfg_pkg::riocfg_state_t state;
  logic                      save_due;
  assign save_due = offset_update && auto_save_q && abs_encoder &&
                    (feed_mode == riocfg_pkg::FEED_ROTARY_INF);
  // save sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= riocfg_pkg::RIOCFG_IDLE;
    end else begin
      unique case (state)
        riocfg_pkg::RIOCFG_IDLE:
          if (save_due) state <= riocfg_pkg::RIOCFG_SAVE;
        riocfg_pkg::RIOCFG_SAVE:
          if (flash_done) state <= riocfg_pkg::RIOCFG_DONE;
        riocfg_pkg::RIOCFG_DONE:
          state <= riocfg_pkg::RIOCFG_IDLE;
        default:
          state <= riocfg_pkg::RIOCFG_IDLE;
      endcase
    end
  end

  // flags and save command answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      auto_save_active   <= 1'b0;
      flash_write_req    <= 1'b0;
      data_transfer_flag <= 1'b0;
      save_warning       <= 1'b0;
      save_accept        <= 1'b0;
    end else begin
      auto_save_active   <= (state == riocfg_pkg::RIOCFG_SAVE);
      flash_write_req    <= (state == riocfg_pkg::RIOCFG_IDLE) && save_due;
      data_transfer_flag <= (state == riocfg_pkg::RIOCFG_SAVE);
      save_warning <= save_data_cmd &&
                      (state == riocfg_pkg::RIOCFG_SAVE);
      save_accept  <= save_data_cmd &&
                      (state != riocfg_pkg::RIOCFG_SAVE);
    end
  end

  // ---------------------------------------------------------------
  // slave input image
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SLAVES; g++) begin : g_slave
      // clear on error only for remote I/O, never sync link
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          slave_in_image[g*DATA_W +: DATA_W] <= '0;
        end else if (slave_comm_error[g]) begin
          if (in_clear_q && slave_is_remote_io[g] &&
              !slave_is_sync_link[g]) begin
            slave_in_image[g*DATA_W +: DATA_W] <= '0;
          end
        end else if (slave_in_valid[g]) begin
          slave_in_image[g*DATA_W +: DATA_W] <=
            slave_in_data[g*DATA_W +: DATA_W];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_stat_span;
    @(posedge clock) disable iff (!rst_n)
    stat_access_en |-> (stat_last == stat_base + 16'h0013);
  endproperty
  a_stat_span: assert property (p_stat_span)
    else $error("status area not twenty words");
  property p_no_access_none;
    @(posedge clock) disable iff (!rst_n)
    (stat_area_type == 3'h0) |-> !stat_access_en;
  endproperty
  a_no_access_none: assert property (p_no_access_none)
    else $error("access on unset area");
  property p_variant;
    @(posedge clock) disable iff (!rst_n)
    !$past(remote_io_capable) |-> !out_access_en && !in_access_en;
  endproperty
  a_variant: assert property (p_variant)
    else $error("area on incapable variant");
  property p_xfer_flag;
    @(posedge clock) disable iff (!rst_n)
    auto_save_active |-> data_transfer_flag;
  endproperty
  a_xfer_flag: assert property (p_xfer_flag)
    else $error("transfer flag off during save");
  property p_warn;
    @(posedge clock) disable iff (!rst_n)
    save_data_cmd && state == riocfg_pkg::RIOCFG_SAVE
      |=> save_warning && !save_accept;
  endproperty
  a_warn: assert property (p_warn)
    else $error("save not warned");
  property p_save_start;
    @(posedge clock) disable iff (!rst_n)
    state == riocfg_pkg::RIOCFG_IDLE && save_due
      |=> flash_write_req ##1 auto_save_active;
  endproperty
  a_save_start: assert property (p_save_start)
    else $error("auto save not started");
  property p_no_save_off;
    @(posedge clock) disable iff (!rst_n)
    !auto_save_q && state == riocfg_pkg::RIOCFG_IDLE
      |=> state == riocfg_pkg::RIOCFG_IDLE;
  endproperty
  a_no_save_off: assert property (p_no_save_off)
    else $error("save with setting off");
  property p_setting_hold;
    @(posedge clock) disable iff (!rst_n)
    !unit_setup_command_bit |=> $stable(auto_save_q);
  endproperty
  a_setting_hold: assert property (p_setting_hold)
    else $error("auto save changed without setup");
  property p_hold_sync;
    @(posedge clock) disable iff (!rst_n)
    slave_comm_error[0] && slave_is_sync_link[0]
      |=> $stable(slave_in_image[DATA_W-1:0]);
  endproperty
  a_hold_sync: assert property (p_hold_sync)
    else $error("sync link data altered on error");
  property p_clear;
    @(posedge clock) disable iff (!rst_n)
    slave_comm_error[0] && in_clear_q && slave_is_remote_io[0] &&
      !slave_is_sync_link[0] |=> slave_in_image[DATA_W-1:0] == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("input not cleared on error");
endmodule // riocfg_top
`default_nettype wire
